//--- logic/otps_core.sv
// Side-region mode, security status byte and lock control on the serial link
`timescale 1ns/1ps
`default_nettype none
`include "otps_regs.svh"

module otps_core
  import otps_pkg::*;
#(
  parameter logic [7:0] OP_CFG_WR = 8'h01,
  parameter logic [7:0] OP_CHIP_ER_A = 8'h60,
  parameter logic [7:0] OP_CHIP_ER_B = 8'hC7,
  parameter logic [7:0] OP_BLK_ER = 8'hD8,
  parameter logic [7:0] OP_SEC_ER = 8'h20,
  parameter logic [7:0] OP_HBLK_ER = 8'h52
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic sio0_i,
  output logic so_o,
  output logic so_oe_n_o,
  input wire logic factory_lock_i,
  input wire logic nv_lock_i,
  input wire logic prog_suspend_i,
  input wire logic prog_resume_i,
  input wire logic erase_suspend_i,
  input wire logic erase_resume_i,
  input wire logic prog_done_i,
  input wire logic prog_fail_i,
  input wire logic erase_done_i,
  input wire logic erase_fail_i,
  input wire logic unlock_clr_i,
  output otps_cmd_t cmd_o,
  output logic otp_mode_o,
  output logic unlock_latch_o,
  output logic nv_lock_wr_o,
  output logic [7:0] status_o
);

  // ---------------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------------
  // Commands barred while the side region is open
  function automatic logic is_barred(input logic [7:0] op);
    is_barred = (op == OP_CFG_WR) || (op == `OTPS_OP_STAT_WR) ||
      (op == OP_CHIP_ER_A) || (op == OP_CHIP_ER_B) ||
      (op == OP_BLK_ER) || (op == OP_SEC_ER) || (op == OP_HBLK_ER);
  endfunction

  // Anything that could alter stored contents
  function automatic logic is_modify(input logic [7:0] op);
    is_modify = is_barred(op) || (op == `OTPS_OP_PROG) ||
      (op == `OTPS_OP_PROG4);
  endfunction

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic sclk_d_reg;
  logic cs_n_d_reg;

  // Two flops per pin; only sio0 is sampled, upper lines never enter
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      sync1_reg <= 3'b100; // Idle pins: deselected, clock low
      sync2_reg <= 3'b100; // No false clock edge right after reset
      sclk_d_reg <= 1'b0;
      cs_n_d_reg <= 1'b1;
    end else begin
      sync1_reg <= {cs_n_i, sclk_i, sio0_i};
      sync2_reg <= sync1_reg;
      sclk_d_reg <= sync2_reg[1];
      cs_n_d_reg <= sync2_reg[2];
    end
  end

  wire cs_n_s = sync2_reg[2];
  wire sclk_s = sync2_reg[1];
  wire si_s = sync2_reg[0];
  wire selected = ~cs_n_s;
  wire sclk_rise = selected & sclk_s & ~sclk_d_reg;
  wire sclk_fall = selected & ~sclk_s & sclk_d_reg;
  wire cs_fall = ~cs_n_s & cs_n_d_reg;
  wire cs_rise = cs_n_s & ~cs_n_d_reg;

  // ---------------------------------------------------------------------
  // Bit and byte counting
  // ---------------------------------------------------------------------
  logic [2:0] bit_cnt_reg;
  logic [1:0] byte_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] op_reg;

  wire [7:0] opcode_next = {shift_reg[6:0], si_s};
  wire byte_end = sclk_rise & (bit_cnt_reg == `OTPS_BITS_PER_BYTE);
  wire op_done = byte_end & (byte_cnt_reg == 2'd0);
  // Byte count saturates; only "exactly one byte" and "at least one byte" matter here
  wire exact_one = (byte_cnt_reg == 2'd1) && (bit_cnt_reg == 3'd0);
  wire exec = cs_rise & exact_one;
  wire had_op = cs_rise & (byte_cnt_reg != 2'd0);

  // Counters restart on every select (chip select falling) so a stray frame cannot skew them
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || cs_fall) begin
      bit_cnt_reg <= 3'd0;
      byte_cnt_reg <= 2'd0;
      shift_reg <= 8'h00;
    end else if (sclk_rise) begin
      shift_reg <= opcode_next;
      bit_cnt_reg <= bit_cnt_reg + 3'd1;
      if (byte_end && byte_cnt_reg != 2'd3) begin
        byte_cnt_reg <= byte_cnt_reg + 2'd1;
      end
    end
  end

  // Opcode latch
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      op_reg <= 8'h00;
    end else if (op_done) begin
      op_reg <= opcode_next;
    end
  end

  // ---------------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------------
  otps_state_t state_reg;
  otps_state_t state_next;

  // Status read is decoded regardless of busy state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      OTPS_IDLE: begin
        if (cs_fall) begin
          state_next = OTPS_OPCODE;
        end
      end
      OTPS_OPCODE: begin
        if (cs_n_s) begin
          state_next = OTPS_IDLE;
        end else if (op_done) begin
          state_next = (opcode_next == `OTPS_OP_STAT_RD) ?
            OTPS_STATUS : OTPS_ARGS;
        end
      end
      OTPS_STATUS, OTPS_ARGS: begin
        if (cs_n_s) begin
          state_next = OTPS_IDLE;
        end
      end
      default: state_next = OTPS_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_reg <= OTPS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------------
  // Mode, latch and lock state
  // ---------------------------------------------------------------------
  logic otp_mode_reg;
  logic unlock_latch_reg;
  logic cust_lock_reg;
  logic factory_reg;
  logic strap_done_reg;
  logic nv_wr_reg;

  wire is_entry = exec & (op_reg == `OTPS_OP_ENTRY);
  wire is_exit = exec & (op_reg == `OTPS_OP_EXIT);
  wire is_unlock = exec & (op_reg == `OTPS_OP_WUNLOCK);
  wire wr_frame = had_op & (op_reg == `OTPS_OP_STAT_WR);
  // Honoured only with latch set, outside the side region, not yet locked
  wire lock_ok = exec & (op_reg == `OTPS_OP_STAT_WR) & unlock_latch_reg &
    ~otp_mode_reg & ~cust_lock_reg;
  wire region_locked = cust_lock_reg | factory_reg;

  // Entry and exit only act when the frame held the opcode alone
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      otp_mode_reg <= 1'b0;
    end else if (is_entry) begin
      otp_mode_reg <= 1'b1;
    end else if (is_exit) begin
      otp_mode_reg <= 1'b0;
    end
  end

  // Latch set wins over any clear arriving in the same cycle
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      unlock_latch_reg <= 1'b0;
    end else if (is_unlock) begin
      unlock_latch_reg <= 1'b1;
    end else if (wr_frame || unlock_clr_i) begin
      unlock_latch_reg <= 1'b0;
    end
  end

  // Nonvolatile bits are caught once after reset release, never in reset
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      strap_done_reg <= 1'b0;
      factory_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      factory_reg <= factory_lock_i;
    end
  end

  // After the strap load customer lock only moves to one; only reset clears it
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cust_lock_reg <= 1'b0;
      nv_wr_reg <= 1'b0;
    end else begin
      nv_wr_reg <= lock_ok;
      if (!strap_done_reg) begin
        cust_lock_reg <= nv_lock_i;
      end else if (lock_ok) begin
        cust_lock_reg <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Volatile suspend and fail flags
  // ---------------------------------------------------------------------
  logic psus_reg;
  logic esus_reg;
  logic pfail_reg;
  logic efail_reg;

  // Set terms win over clears; flags never feed back into the engine
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      psus_reg <= 1'b0;
      esus_reg <= 1'b0;
      pfail_reg <= 1'b0;
      efail_reg <= 1'b0;
    end else begin
      psus_reg <= prog_suspend_i | (psus_reg & ~prog_resume_i);
      esus_reg <= erase_suspend_i | (esus_reg & ~erase_resume_i);
      pfail_reg <= prog_fail_i | (pfail_reg & ~prog_done_i);
      efail_reg <= erase_fail_i | (efail_reg & ~erase_done_i);
    end
  end

  // Reserved bits 7 and 4 read as zero
  assign status_o = {1'b0, efail_reg, pfail_reg, 1'b0, esus_reg,
    psus_reg, cust_lock_reg, factory_reg};

  // ---------------------------------------------------------------------
  // Command hand-off
  // ---------------------------------------------------------------------
  otps_cmd_t cmd_reg;
  wire rej_next = otp_mode_reg & (is_barred(opcode_next) |
    (region_locked & is_modify(opcode_next)));

  // Side-region target follows the mode flag at opcode time
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cmd_reg <= '0;
    end else begin
      cmd_reg.valid <= op_done;
      if (op_done) begin
        cmd_reg.opcode <= opcode_next;
        cmd_reg.to_otp <= otp_mode_reg;
        cmd_reg.reject <= rej_next;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Status shift-out
  // ---------------------------------------------------------------------
  logic [2:0] out_idx_reg;
  logic so_reg;

  // MSB first on falling edges; index wraps so the byte repeats
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || state_reg != OTPS_STATUS) begin
      out_idx_reg <= 3'd0;
      so_reg <= 1'b0;
    end else if (sclk_fall) begin
      so_reg <= status_o[3'd7 - out_idx_reg];
      out_idx_reg <= out_idx_reg + 3'd1;
    end
  end

  assign so_o = so_reg;
  assign so_oe_n_o = (state_reg != OTPS_STATUS);
  assign cmd_o = cmd_reg;
  assign otp_mode_o = otp_mode_reg;
  assign unlock_latch_o = unlock_latch_reg;
  assign nv_lock_wr_o = nv_wr_reg;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking chk_clk @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  chk_entry_sets_mode: assert property (is_entry |=> otp_mode_o)
    else $error("entry did not set mode");
  chk_exit_clears_mode: assert property (is_exit |=> !otp_mode_o)
    else $error("exit did not clear mode");
  chk_lock_needs_latch: assert property ($rose(cust_lock_reg) &&
    $past(strap_done_reg) |-> $past(unlock_latch_reg && !otp_mode_reg))
    else $error("lock set without latch");
  chk_lock_pulse: assert property ($rose(cust_lock_reg) &&
    $past(strap_done_reg) |-> nv_lock_wr_o)
    else $error("lock write pulse missing");
  chk_latch_cleared: assert property (wr_frame && !is_unlock
    |=> !unlock_latch_o)
    else $error("latch kept after write frame");
  chk_lock_sticky: assert property (strap_done_reg && cust_lock_reg
    |=> cust_lock_reg)
    else $error("lock bit fell");
  chk_barred_reject: assert property (op_done && otp_mode_reg &&
    is_barred(opcode_next) |=> cmd_o.valid && cmd_o.reject)
    else $error("barred command passed");
  chk_status_drive: assert property ($rose(state_reg == OTPS_STATUS)
    |-> $past(opcode_next) == `OTPS_OP_STAT_RD) else $error("no read opcode");
  chk_pause_follow: assert property (prog_suspend_i |=> status_o[2])
    else $error("program pause flag not set");
  chk_pfail_clear: assert property (prog_done_i && !prog_fail_i
    |=> !status_o[5])
    else $error("program fail not cleared");
  chk_factory_fixed: assert property (strap_done_reg
    |=> $stable(factory_reg))
    else $error("factory bit changed");
  cov_status_read: cover property (sclk_fall && out_idx_reg == 3'd7);
  cov_customer_lock: cover property (nv_lock_wr_o);
  cov_enter_exit: cover property (is_entry ##[1:1000] is_exit);
endmodule
`default_nettype wire

//--- logic/otps_pkg.sv
// Types shared by the OTP status block
`default_nettype none
package otps_pkg;
  // Frame sequencer, Gray coded along idle, opcode, status
  typedef enum logic [1:0] {
    OTPS_IDLE = 2'b00,
    OTPS_OPCODE = 2'b01,
    OTPS_STATUS = 2'b11,
    OTPS_ARGS = 2'b10
  } otps_state_t;

  // Decoded command handed to the array engine
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic to_otp;
    logic reject;
  } otps_cmd_t;
endpackage
`default_nettype wire

//--- logic/otps_regs.svh
// Opcodes, status bit positions and reset values for the OTP status block
`ifndef OTPS_REGS_SVH
`define OTPS_REGS_SVH

// -----------------------------------------------------------------------
// Command opcodes
// -----------------------------------------------------------------------
`define OTPS_OP_ENTRY 8'hB1
`define OTPS_OP_EXIT 8'hC1
`define OTPS_OP_STAT_RD 8'h2B
`define OTPS_OP_STAT_WR 8'h2F
`define OTPS_OP_WUNLOCK 8'h06
`define OTPS_OP_PROG 8'h02
`define OTPS_OP_PROG4 8'h38

// -----------------------------------------------------------------------
// Status byte fields
// -----------------------------------------------------------------------
`define OTPS_BIT_FACTORY 0
`define OTPS_BIT_CUST_LOCK 1
`define OTPS_BIT_PROG_PAUSE 2
`define OTPS_BIT_ERASE_PAUSE 3
`define OTPS_BIT_PROG_FAIL 5
`define OTPS_BIT_ERASE_FAIL 6
`define OTPS_STAT_RESET 8'h00
`define OTPS_BITS_PER_BYTE 3'd7

`endif

//--- tb/otps_host_model.sv
// Host serial controller model that frames commands on the link
`timescale 1ns/1ps
`default_nettype none
module otps_host_model (
  input wire logic so_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic sio0_o
);
  // ---------------------------------------------------------------
  // Link idle state
  // ---------------------------------------------------------------
  // Mode 0: the clock rests low and stands still outside frames
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sio0_o = 1'b1;
  end

  // ---------------------------------------------------------------
  // One frame: opcode MSB first, an optional stray bit, then reads
  // ---------------------------------------------------------------
  // Half period 62.5 ns keeps each level well over four system clocks
  task automatic frame(input logic [7:0] op, input logic extra,
                       input int nrd, output logic [15:0] rd);
    logic [8:0] tx;
    int n;
    tx = {op, ~op[0]};
    n = extra ? 9 : 8;
    rd = 16'h0000;
    cs_n_o = 1'b0;
    #62.5;
    for (int i = 0; i < n + nrd; i++) begin
      // Unused data line toggles so it never looks like a stale value
      sio0_o = (i < n) ? tx[8 - i] : ~sio0_o;
      #62.5;
      sclk_o = 1'b1;
      if (i >= n) begin
        rd = {rd[14:0], so_i};
      end
      #62.5;
      sclk_o = 1'b0;
    end
    #62.5;
    cs_n_o = 1'b1;
    sio0_o = ~sio0_o;
    #200;
  endtask
endmodule
`default_nettype wire

//--- tb/test_otps_core.sv
// Self-checking bench for the OTP mode and security status block
`timescale 1ns/1ps
`default_nettype none
`include "otps_regs.svh"
module test_otps_core;
  import otps_pkg::*;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic fl_i = 1'b0;
  logic nvl_i = 1'b0;
  logic [8:0] ev_i = 9'h000;
  logic cs_n, sclk, sio0, so_o, so_oe_n_o, otp_mode_o, latch_o, wr_o;
  logic [7:0] status_o;
  otps_cmd_t cmd_o, last_cmd;
  int mismatches = 0;
  int total_checks = 0;
  int wr_pulses = 0;
  logic [15:0] rd;

  // ---------------------------------------------------------------
  // Clock, design and host
  // ---------------------------------------------------------------
  always #5 clock_i = ~clock_i;

  otps_core i_otps_core (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .cs_n_i(cs_n), .sclk_i(sclk), .sio0_i(sio0), .so_o(so_o),
    .so_oe_n_o(so_oe_n_o), .factory_lock_i(fl_i), .nv_lock_i(nvl_i),
    .prog_suspend_i(ev_i[7]), .prog_resume_i(ev_i[6]),
    .erase_suspend_i(ev_i[5]), .erase_resume_i(ev_i[4]),
    .prog_done_i(ev_i[3]), .prog_fail_i(ev_i[2]),
    .erase_done_i(ev_i[1]), .erase_fail_i(ev_i[0]),
    .unlock_clr_i(ev_i[8]), .cmd_o(cmd_o), .otp_mode_o(otp_mode_o),
    .unlock_latch_o(latch_o), .nv_lock_wr_o(wr_o), .status_o(status_o));

  otps_host_model i_otps_host_model (.so_i(so_o), .cs_n_o(cs_n),
    .sclk_o(sclk), .sio0_o(sio0));

  // Remember the last decoded command and count lock commits
  always @(posedge clock_i) begin
    if (cmd_o.valid === 1'b1) last_cmd <= cmd_o;
    if (wr_o === 1'b1) wr_pulses <= wr_pulses + 1;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ev(input logic [8:0] m);
    @(posedge clock_i) #1 ev_i = m;
    @(posedge clock_i) #1 ev_i = 9'h000;
    repeat (2) @(posedge clock_i);
  endtask

  task automatic f(input logic [7:0] op, input logic extra);
    i_otps_host_model.frame(op, extra, 0, rd);
  endtask

  task automatic do_reset(input logic fl, input logic nvl);
    @(posedge clock_i) #1 rst_n_i = 1'b0;
    fl_i = fl;
    nvl_i = nvl;
    repeat (16) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    repeat (4) @(posedge clock_i);
  endtask

  // Prog command: opcode, side-region target and refusal as a word
  task automatic prog_chk(input logic to_otp, input logic rej);
    f(`OTPS_OP_PROG, 1'b0);
    chk({last_cmd.opcode, last_cmd.to_otp, last_cmd.reject},
        {`OTPS_OP_PROG, to_otp, rej});
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk(status_o, 16'h0000);
    chk({otp_mode_o, latch_o, so_oe_n_o}, 16'h0001);
    $display("test reset done");
  endtask

  // Suspends and failures set, read twice over, then resume and pass
  task automatic t_flags();
    ev(9'h0A0);
    ev(9'h00F);
    chk(status_o, 16'h006C);
    i_otps_host_model.frame(`OTPS_OP_STAT_RD, 1'b0, 16, rd);
    chk(rd, 16'h6C6C);
    chk(so_oe_n_o, 16'h0001);
    ev(9'h05A);
    chk(status_o, 16'h0000);
    $display("test flags done");
  endtask

  task automatic t_otp();
    f(`OTPS_OP_ENTRY, 1'b0);
    chk(otp_mode_o, 16'h0001);
    prog_chk(1'b1, 1'b0);
    f(8'hD8, 1'b0);
    chk(last_cmd.reject, 16'h0001);
    f(`OTPS_OP_WUNLOCK, 1'b0);
    f(`OTPS_OP_STAT_WR, 1'b0);
    chk({status_o, latch_o}, 16'h0000);
    f(`OTPS_OP_EXIT, 1'b1);
    chk(otp_mode_o, 16'h0001);
    f(`OTPS_OP_EXIT, 1'b0);
    chk(otp_mode_o, 16'h0000);
    prog_chk(1'b0, 1'b0);
    $display("test otp mode done");
  endtask

  task automatic t_lock();
    f(`OTPS_OP_STAT_WR, 1'b0);
    chk(status_o, 16'h0000);
    f(`OTPS_OP_WUNLOCK, 1'b0);
    chk(latch_o, 16'h0001);
    ev(9'h100);
    chk(latch_o, 16'h0000);
    f(`OTPS_OP_WUNLOCK, 1'b0);
    f(`OTPS_OP_STAT_WR, 1'b1);
    chk({status_o, latch_o}, 16'h0000);
    f(`OTPS_OP_WUNLOCK, 1'b0);
    f(`OTPS_OP_STAT_WR, 1'b0);
    chk({status_o, latch_o}, 16'h0004);
    chk(16'(wr_pulses), 16'h0001);
    i_otps_host_model.frame(`OTPS_OP_STAT_RD, 1'b0, 16, rd);
    chk(rd, 16'h0202);
    f(`OTPS_OP_WUNLOCK, 1'b0);
    f(`OTPS_OP_STAT_WR, 1'b0);
    chk(16'(wr_pulses), 16'h0001);
    f(`OTPS_OP_ENTRY, 1'b0);
    prog_chk(1'b1, 1'b1);
    f(`OTPS_OP_EXIT, 1'b0);
    $display("test lock done");
  endtask

  // Stored lock levels come back after a second reset
  task automatic t_factory();
    do_reset(1'b1, 1'b1);
    chk(status_o, 16'h0003);
    f(`OTPS_OP_ENTRY, 1'b0);
    prog_chk(1'b1, 1'b1);
    $display("test factory done");
  endtask

  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Some 23 frames of under 5 us each; 200 us leaves ample margin
  initial begin
    #200_000;
    mismatches++;
    wrap_up();
  end

  initial begin
    do_reset(1'b0, 1'b0);
    t_reset();
    t_flags();
    t_otp();
    t_lock();
    t_factory();
    wrap_up();
  end
endmodule
`default_nettype wire
